// [bench/bps_charger_model.sv]
/*
  Oscillator and smart charger model at the far side of the supervisor.
  Assumes one core clock; one tick every DIV core cycles.
*/
`timescale 1ns/10ps
module bps_charger_model
#(
  parameter int DIV = 2
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic broadcast_req,
  output logic lfo_tick,
  output int bc_count
);
  int div_cnt;
  // ==========================================================
  // oscillator tick, one core cycle wide
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      div_cnt <= 0;
      lfo_tick <= 1'b0;
    end
    else
    begin
      div_cnt <= (div_cnt == DIV - 1) ? 0 : div_cnt + 1;
      lfo_tick <= (div_cnt == DIV - 1);
    end
  end
  // charger counts broadcast requests it receives
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      bc_count <= 0;
    else if (broadcast_req)
      bc_count <= bc_count + 1;
  end
endmodule : bps_charger_model

// [bench/testbench.sv]
/*
  Self-checking bench for the supervisor with a charger model.
  Assumes shortened counts: 4 ticks a cycle, logs at 3 and 5 cycles.
*/
`timescale 1ns/10ps
module testbench;
  import bps_pkg::*;
  logic core_clk, rst, wr, rd, cur, flt;
  logic [3:0] addr;
  logic [15:0] wdata, rdata, rem, rv;
  logic [1:0] temp;
  logic work, trip_n, pull, fuse, chg_en, bc, lws, lwl, irq;
  int failures, total_checks, n_work, n_bc, n_s, n_l, w0, b0, s0, l0;
  logic tick, vhi, cflt, bal, calm;
  logic [15:0] cmv;
  // ==========================================================
  // design and far side
  bps_supervisor #(.CYCLE_TICKS(4), .SHORT_CYCLES(3), .LONG_CYCLES(5))
    bps_supervisor_i (.core_clk(core_clk), .rst(rst), .lfo_tick(tick),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .remaining_charge_reading(rem),
    .relative_charge_percent(7'h32), .current_flow_pin(cur),
    .second_fault_pin(flt), .temp_range_pin(temp),
    .cell_v_high_pin(vhi), .cell_mv(cmv), .charge_fault(cflt),
    .work_cycle(work), .low_power(), .capacity_trip_irq(trip_n),
    .capacity_trip_pullup(pull), .fuse_drive(fuse),
    .charge_enable(chg_en), .charge_mv(), .charge_ma(),
    .broadcast_req(bc), .balance_en(bal), .charge_alarm(calm),
    .discharge_alarm(), .log_wb_short(lws), .log_wb_long(lwl),
    .seg_out(), .irq(irq));
  bps_charger_model #(.DIV(2)) bps_charger_model_i (.core_clk(core_clk),
    .rst(rst), .broadcast_req(bc), .lfo_tick(tick), .bc_count(n_bc));
  // clock and pulse counters
  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    n_work <= n_work + int'(work === 1'b1);
    n_s <= n_s + int'(lws === 1'b1);
    n_l <= n_l + int'(lwl === 1'b1);
  end
  // ==========================================================
  // shared tasks
  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic reg_write(logic [3:0] a, logic [15:0] d);
    @(posedge core_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : reg_write
  task automatic reg_read(logic [3:0] a);
    @(posedge core_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask : reg_read
  task automatic wait_clk(int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_clk
  task automatic snap();
    w0 = n_work;
    b0 = n_bc;
    s0 = n_s;
    l0 = n_l;
  endtask : snap
  // ==========================================================
  // scenarios
  task automatic t_reset();
    reg_read(REG_STATUS);
    check("status", rv, 16'h0000);
    reg_read(REG_SLEEP_IVL);
    check("sleep_ivl", rv, SLEEP_IVL_RST);
    reg_read(REG_BAL_THR);
    check("bal_thr", rv, BAL_THR_RST);
    reg_write(4'hf, 16'h1234);
    reg_read(4'hf);
    check("unmapped", rv, 16'h0000);
    check("trip_pin", trip_n, 1'b1);
    $display("test reset done");
  endtask : t_reset
  task automatic t_normal();
    snap();
    wait_clk(120);
    check("work_cycles", 16'(n_work - w0), 16'h000f);
    check("broadcasts", 16'(n_bc - b0), 16'h000f);
    check("log_short", 16'(n_s - s0), 16'h0005);
    check("log_long", 16'(n_l - l0), 16'h0003);
    $display("test normal done");
  endtask : t_normal
  task automatic t_trip();
    reg_write(REG_TRIP_SET, 16'h0064);
    reg_write(REG_TRIP_CLR, 16'h00c8);
    reg_write(REG_IRQ_EN, 16'h0000);
    reg_write(REG_CTRL, 16'h0004);
    wait_clk(2);
    check("pullup", pull, 1'b1);
    rem <= 16'h0032;
    wait_clk(20);
    check("trip_pin", trip_n, 1'b0);
    check("irq_masked", irq, 1'b0);
    reg_read(REG_STATUS);
    check("trip_bit", rv[3], 1'b1);
    reg_write(REG_IRQ_EN, 16'h0002);
    wait_clk(1);
    check("irq_on", irq, 1'b1);
    rem <= 16'h012c;
    wait_clk(20);
    check("trip_pin", trip_n, 1'b1);
    reg_read(REG_STATUS);
    check("trip_bit", rv[3], 1'b0);
    check("irq_sticky", irq, 1'b1);
    reg_write(REG_IRQ_CLR, 16'h0002);
    wait_clk(1);
    check("irq_clr", irq, 1'b0);
    reg_write(REG_CTRL, 16'h0000);
    wait_clk(2);
    check("pullup", pull, 1'b0);
    $display("test trip done");
  endtask : t_trip
  task automatic t_sleep();
    reg_write(REG_CTRL, 16'h0001);
    wait_clk(40);
    reg_read(REG_STATUS);
    check("mode", rv[1:0], 2'h1);
    snap();
    wait_clk(128);
    check("sleep_cycles", 16'(n_work - w0), 16'h0004);
    cur <= 1'b1;
    wait_clk(10);
    reg_read(REG_STATUS);
    check("mode", rv[1:0], 2'h0);
    reg_write(REG_CTRL, 16'h0000);
    cur <= 1'b0;
    wait_clk(16);
    snap();
    wait_clk(64);
    check("resumed", 16'(n_work - w0), 16'h0008);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_shut();
    reg_write(REG_CTRL, 16'h0002);
    wait_clk(16);
    snap();
    wait_clk(200);
    check("shut_cycles", 16'(n_work - w0), 16'h0000);
    reg_write(REG_CTRL, 16'h0000);
    $display("test shutdown done");
  endtask : t_shut
  task automatic t_temp();
    temp <= 2'h0;
    wait_clk(20);
    check("charge_en", chg_en, 1'b0);
    temp <= 2'h2;
    wait_clk(20);
    check("charge_en", chg_en, 1'b1);
    vhi <= 1'b1;
    cflt <= 1'b1;
    reg_write(REG_BAL_THR, 16'h0e00);
    wait_clk(20);
    check("balance_en", bal, 1'b1);
    check("charge_alarm", calm, 1'b1);
    reg_write(REG_BAL_THR, 16'h0f00);
    cflt <= 1'b0;
    wait_clk(20);
    check("balance_en", bal, 1'b0);
    check("charge_alarm", calm, 1'b0);
    $display("test temperature done");
  endtask : t_temp
  task automatic t_fuse();
    flt <= 1'b1;
    wait_clk(20);
    check("fuse", fuse, 1'b1);
    flt <= 1'b0;
    wait_clk(20);
    check("fuse_held", fuse, 1'b1);
    $display("test fuse done");
  endtask : t_fuse
  // ==========================================================
  // verdict and run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (3000) @(posedge core_clk);
    failures++;
    wrap_up();
  end
  initial
  begin
    {failures, total_checks, n_work, n_s, n_l} = '0;
    {wr, rd, cur, flt} = 4'h0;
    addr = 4'h0;
    wdata = 16'h0000;
    rem = 16'h012c;
    {vhi, cflt} = 2'b00;
    cmv = 16'h0e10;
    temp = 2'h1;
    rst = 1'b1;
    wait_clk(2);
    rst <= 1'b0;
    t_reset();
    t_normal();
    t_trip();
    t_sleep();
    t_shut();
    t_temp();
    t_fuse();
    wrap_up();
  end
endmodule : testbench

// [hw/bps_pkg.sv]
/*
  Constants and types shared by the battery pack supervisor.
  Assumes a 10 MHz core clock and a low-frequency oscillator tick input.
*/
package bps_pkg;
  // ==========================================================
  // clock and timing
  localparam int unsigned CORE_HZ = 10000000;
  localparam int unsigned LFO_HZ = 262144;
  localparam int unsigned NORMAL_CYCLE_MS = 250;
  // lfo ticks per 250 ms cycle
  localparam int unsigned NORMAL_CYCLE_TICKS = LFO_HZ * NORMAL_CYCLE_MS / 1000;
  localparam int unsigned LOG_SHORT_HOURS = 2;
  localparam int unsigned LOG_LONG_HOURS = 10;
  // log periods counted in normal cycles (4 per second)
  localparam int unsigned LOG_SHORT_CYCLES = LOG_SHORT_HOURS * 3600 * 4;
  localparam int unsigned LOG_LONG_CYCLES = LOG_LONG_HOURS * 3600 * 4;

  // ==========================================================
  // register offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_TRIP_SET = 4'h2;
  localparam logic [3:0] REG_TRIP_CLR = 4'h3;
  localparam logic [3:0] REG_SLEEP_IVL = 4'h4;
  localparam logic [3:0] REG_CHG = 4'h5;
  localparam logic [3:0] REG_BAL_THR = 4'h6;
  localparam logic [3:0] REG_IRQ_STAT = 4'h7;
  localparam logic [3:0] REG_IRQ_CLR = 4'h8;
  localparam logic [3:0] REG_IRQ_EN = 4'h9;
  localparam logic [3:0] REG_DISP = 4'ha;

  // ctrl fields
  localparam int CTRL_SLEEP_REQ = 0;
  localparam int CTRL_SHUT_REQ = 1;
  localparam int CTRL_TRIP_EN = 2;
  localparam int CTRL_DISP_LSB = 4;
  // irq status bits
  localparam int IRQ_CYCLE = 0;
  localparam int IRQ_TRIP = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_WAKE = 3;
  localparam int IRQ_LOG = 4;
  localparam int IRQ_W = 5;

  // reset values
  localparam logic [15:0] SLEEP_IVL_RST = 16'h0004;
  localparam logic [15:0] TRIP_SET_RST = 16'h0000;
  localparam logic [15:0] TRIP_CLR_RST = 16'h0000;
  localparam logic [15:0] BAL_THR_RST = 16'hffff;

  typedef enum logic [1:0] {
    BPS_NORMAL = 2'b00,
    BPS_SLEEP = 2'b01,
    BPS_SHUT = 2'b10
  } bps_mode_t;
endpackage : bps_pkg

// [hw/bps_supervisor.sv]
/*
  Battery pack supervisor: power mode scheduler, capacity trip output,
  fuse drive, charge control reporting, segment display, log timers.
  Assumes lfo_tick is a one-cycle pulse on core_clk from the oscillator
  divider; fault, current and temperature inputs arrive from pins.
*/
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/10ps
module bps_supervisor
  import bps_pkg::*;
#(
  parameter int unsigned CYCLE_TICKS = NORMAL_CYCLE_TICKS,
  parameter int unsigned SHORT_CYCLES = LOG_SHORT_CYCLES,
  parameter int unsigned LONG_CYCLES = LOG_LONG_CYCLES,
  parameter int unsigned SEG_MAX = 5
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic lfo_tick,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic [15:0] remaining_charge_reading,
  input wire logic [6:0] relative_charge_percent,
  input wire logic current_flow_pin,
  input wire logic second_fault_pin,
  input wire logic [1:0] temp_range_pin,
  input wire logic cell_v_high_pin,
  input wire logic [15:0] cell_mv,
  input wire logic charge_fault,
  output logic work_cycle,
  output logic low_power,
  output logic capacity_trip_irq,
  output logic capacity_trip_pullup,
  output logic fuse_drive,
  output logic charge_enable,
  output logic [15:0] charge_mv,
  output logic [15:0] charge_ma,
  output logic broadcast_req,
  output logic balance_en,
  output logic charge_alarm,
  output logic discharge_alarm,
  output logic log_wb_short,
  output logic log_wb_long,
  output logic [SEG_MAX-1:0] seg_out,
  output logic irq
);
  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_s1_r, pin_s2_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
    end
    else
    begin
      pin_s1_r <= {cell_v_high_pin, temp_range_pin[0], second_fault_pin,
                   current_flow_pin};
      pin_s2_r <= pin_s1_r;
    end
  logic [1:0] trs1_r, trs2_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      trs1_r <= 2'h0;
      trs2_r <= 2'h0;
    end
    else
    begin
      trs1_r <= temp_range_pin;
      trs2_r <= trs1_r;
    end
  logic cur_s, flt_s, vhi_s;
  assign cur_s = pin_s2_r[0];
  assign flt_s = pin_s2_r[1];
  assign vhi_s = pin_s2_r[3];

  // ==========================================================
  // registers
  logic [7:0] ctrl_r;
  logic [15:0] trip_set_r, trip_clr_r, sleep_ivl_r, bal_thr_r;
  logic [15:0] chg_cfg_r;
  logic [IRQ_W-1:0] irq_stat_r, irq_en_r, irq_ev;
  bps_mode_t mode_r;
  logic trip_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      ctrl_r <= 8'h00;
      trip_set_r <= TRIP_SET_RST;
      trip_clr_r <= TRIP_CLR_RST;
      sleep_ivl_r <= SLEEP_IVL_RST;
      bal_thr_r <= BAL_THR_RST;
      chg_cfg_r <= 16'h0000;
      irq_en_r <= '0;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        REG_CTRL: ctrl_r <= reg_wdata[7:0];
        REG_TRIP_SET: trip_set_r <= reg_wdata;
        REG_TRIP_CLR: trip_clr_r <= reg_wdata;
        REG_SLEEP_IVL: sleep_ivl_r <= reg_wdata;
        REG_CHG: chg_cfg_r <= reg_wdata;
        REG_BAL_THR: bal_thr_r <= reg_wdata;
        REG_IRQ_EN: irq_en_r <= reg_wdata[IRQ_W-1:0];
        default: ;
      endcase
    end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        REG_CTRL: reg_rdata <= {8'h00, ctrl_r};
        REG_STATUS: reg_rdata <= {11'h000, flt_s, trip_r, fuse_drive,
                                  mode_r};
        REG_TRIP_SET: reg_rdata <= trip_set_r;
        REG_TRIP_CLR: reg_rdata <= trip_clr_r;
        REG_SLEEP_IVL: reg_rdata <= sleep_ivl_r;
        REG_CHG: reg_rdata <= chg_cfg_r;
        REG_BAL_THR: reg_rdata <= bal_thr_r;
        REG_IRQ_STAT: reg_rdata <= {11'h000, irq_stat_r};
        REG_IRQ_EN: reg_rdata <= {11'h000, irq_en_r};
        REG_DISP: reg_rdata <= {{(16-SEG_MAX){1'b0}}, seg_out};
        default: reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;

  // ==========================================================
  // power mode and cycle scheduler
  logic [31:0] tick_cnt_r;
  logic [15:0] sleep_cnt_r;
  logic cycle_due, wake;
  assign wake = (cur_s || flt_s) && mode_r == BPS_SLEEP;
  assign cycle_due = lfo_tick && tick_cnt_r == CYCLE_TICKS - 1;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      mode_r <= BPS_NORMAL;
    else
    begin
      unique case (mode_r)
        BPS_NORMAL:
          if (ctrl_r[CTRL_SHUT_REQ])
            mode_r <= BPS_SHUT;
          else if (ctrl_r[CTRL_SLEEP_REQ] && !cur_s && !flt_s)
            mode_r <= BPS_SLEEP;
        BPS_SLEEP:
          if (ctrl_r[CTRL_SHUT_REQ])
            mode_r <= BPS_SHUT;
          else if (wake)
            mode_r <= BPS_NORMAL;
        BPS_SHUT:
          if (!ctrl_r[CTRL_SHUT_REQ])
            mode_r <= BPS_NORMAL;
        default: mode_r <= BPS_NORMAL;
      endcase
    end

  // tick counter keeps running in sleep so wake resumes on schedule; held at zero in shutdown
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      tick_cnt_r <= 32'h0;
    else if (mode_r == BPS_SHUT)
      tick_cnt_r <= 32'h0;
    else if (lfo_tick)
      tick_cnt_r <= cycle_due ? 32'h0 : tick_cnt_r + 32'h1;

  // sleep counts normal slots, works every sleep_ivl slots
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      sleep_cnt_r <= 16'h0;
    else if (mode_r != BPS_SLEEP)
      sleep_cnt_r <= 16'h0;
    else if (cycle_due)
      sleep_cnt_r <= (sleep_cnt_r + 16'h1 >= sleep_ivl_r) ? 16'h0
                     : sleep_cnt_r + 16'h1;

  // one-cycle work pulse, low power otherwise
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      work_cycle <= 1'b0;
    else
      work_cycle <= cycle_due && (mode_r == BPS_NORMAL
        || (mode_r == BPS_SLEEP
            && sleep_cnt_r + 16'h1 >= sleep_ivl_r));
  assign low_power = !work_cycle;

  // ==========================================================
  // capacity trip with hysteresis
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      trip_r <= 1'b0;
    else if (!ctrl_r[CTRL_TRIP_EN])
      trip_r <= 1'b0;
    else if (work_cycle)
    begin
      if (remaining_charge_reading <= trip_set_r)
        trip_r <= 1'b1;
      else if (remaining_charge_reading > trip_clr_r)
        trip_r <= 1'b0;
    end
  // pin released at once when the feature is switched off
  assign capacity_trip_irq = !(trip_r && ctrl_r[CTRL_TRIP_EN]);
  assign capacity_trip_pullup = ctrl_r[CTRL_TRIP_EN];

  // ==========================================================
  // permanent fail fuse, latched until reset
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      fuse_drive <= 1'b0;
    else if (flt_s && mode_r != BPS_SHUT)
      fuse_drive <= 1'b1;

  // ==========================================================
  // charge control; range 0 is out of range
  logic temp_ok;
  assign temp_ok = trs2_r != 2'b00;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      charge_enable <= 1'b0;
      charge_mv <= 16'h0;
      charge_ma <= 16'h0;
      broadcast_req <= 1'b0;
      balance_en <= 1'b0;
      charge_alarm <= 1'b0;
      discharge_alarm <= 1'b0;
    end
    else
    begin
      broadcast_req <= 1'b0;
      if (work_cycle)
      begin
        charge_enable <= temp_ok && !fuse_drive;
        charge_mv <= temp_ok ? {4'h0, chg_cfg_r[11:0]}
                   - {12'h0, trs2_r, 2'b00} : 16'h0;
        charge_ma <= temp_ok ? {8'h0, chg_cfg_r[15:12], 4'h0}
                   >> trs2_r : 16'h0;
        broadcast_req <= 1'b1;
        balance_en <= vhi_s && cell_mv >= bal_thr_r;
        charge_alarm <= charge_fault || !temp_ok;
        discharge_alarm <= trip_r || fuse_drive;
      end
    end

  // ==========================================================
  // lifetime log write-back timers
  logic [31:0] log_s_r, log_l_r;
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      log_s_r <= 32'h0;
      log_l_r <= 32'h0;
      log_wb_short <= 1'b0;
      log_wb_long <= 1'b0;
    end
    else
    begin
      log_wb_short <= 1'b0;
      log_wb_long <= 1'b0;
      if (cycle_due && mode_r != BPS_SHUT)
      begin
        log_s_r <= (log_s_r == SHORT_CYCLES - 1) ? 32'h0 : log_s_r + 32'h1;
        log_l_r <= (log_l_r == LONG_CYCLES - 1) ? 32'h0 : log_l_r + 32'h1;
        log_wb_short <= log_s_r == SHORT_CYCLES - 1;
        log_wb_long <= log_l_r == LONG_CYCLES - 1;
      end
    end

  // ==========================================================
  // segment display: bar of capacity or fail code
  logic [2:0] seg_n;
  assign seg_n = ctrl_r[CTRL_DISP_LSB +: 3] < 3'd3 ? 3'd3
    : ctrl_r[CTRL_DISP_LSB +: 3] > 3'd5 ? 3'd5 : ctrl_r[CTRL_DISP_LSB +: 3];
  genvar g;
  generate
    for (g = 0; g < SEG_MAX; g++)
    begin : g_seg
      always_ff @(posedge core_clk or posedge rst)
        if (rst)
          seg_out[g] <= 1'b0;
        else if (g >= seg_n)
          seg_out[g] <= 1'b0;
        else if (fuse_drive)
          seg_out[g] <= (g % 2) == 0;
        else
          seg_out[g] <= 10'(relative_charge_percent) * seg_n
                        > 10'(g * 100);
    end
  endgenerate

  // ==========================================================
  // interrupts: set wins over clear
  assign irq_ev = {log_wb_long | log_wb_short, wake, flt_s & ~fuse_drive,
                   trip_r & work_cycle, work_cycle};
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~((reg_wr && reg_addr == REG_IRQ_CLR)
                    ? reg_wdata[IRQ_W-1:0] : '0)) | irq_ev;
  assign irq = |(irq_stat_r & irq_en_r);

  // ==========================================================
  // checks
  a_shut_idle: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == BPS_SHUT |=> !work_cycle) else $error("work in shutdown");
  a_fuse_blow: assert property (@(posedge core_clk) disable iff (rst)
    flt_s && mode_r != BPS_SHUT |=> fuse_drive)
    else $error("fuse not driven");
  a_wake_exit: assert property (@(posedge core_clk) disable iff (rst)
    mode_r == BPS_SLEEP && cur_s && !ctrl_r[CTRL_SHUT_REQ]
    |=> mode_r == BPS_NORMAL) else $error("no wake");
  a_normal_cycle: assert property (@(posedge core_clk) disable iff (rst)
    cycle_due && mode_r == BPS_NORMAL |=> work_cycle)
    else $error("missed cycle");
  a_trip_pullup: assert property (@(posedge core_clk) disable iff (rst)
    trip_r |-> capacity_trip_pullup && !capacity_trip_irq)
    else $error("trip pin wrong");
  a_temp_inhibit: assert property (@(posedge core_clk) disable iff (rst)
    work_cycle && !temp_ok |=> !charge_enable)
    else $error("charge not inhibited");
  a_bal_gate: assert property (@(posedge core_clk) disable iff (rst)
    work_cycle |=> balance_en == ($past(vhi_s)
    && $past(cell_mv) >= $past(bal_thr_r)))
    else $error("balance below threshold");
  a_bcast_pulse: assert property (@(posedge core_clk) disable iff (rst)
    work_cycle |=> broadcast_req ##1 !broadcast_req)
    else $error("broadcast missing");
  a_log_long: assert property (@(posedge core_clk) disable iff (rst)
    log_wb_long |-> $past(log_l_r) == LONG_CYCLES - 1)
    else $error("long log early");
  c_sleep: cover property (@(posedge core_clk) mode_r == BPS_SLEEP);
  c_wake: cover property (@(posedge core_clk) wake);
  c_trip: cover property (@(posedge core_clk) $rose(trip_r));
  c_fuse: cover property (@(posedge core_clk) $rose(fuse_drive));
endmodule : bps_supervisor
